/* File: verilog/cdt_regs.svh */
`ifndef CDT_REGS_SVH
`define CDT_REGS_SVH

// Byte addresses of the register words.
`define CDT_A_START 8'h00
`define CDT_A_CTRL0 8'h04
`define CDT_A_CTRL1 8'h08
`define CDT_A_RLD0  8'h0C
`define CDT_A_RLD1  8'h10
`define CDT_A_CNT0  8'h14
`define CDT_A_CNT1  8'h18
`define CDT_A_STAT  8'h1C
`define CDT_A_MASK  8'h20
`define CDT_A_PINS  8'h24

// Field positions inside a control word.
`define CDT_F_MODE  1:0
`define CDT_F_PULSE 2
`define CDT_F_TRIG  3
`define CDT_F_RISE  4
`define CDT_F_SRC   6:5
`define CDT_F_NBR   7
`define CDT_CTRL_W  8

// Reset values.
`define CDT_RST_CTRL 8'h00
`define CDT_RST_CNT  16'hFFFF

// Count source dividers, powers of two.
`define CDT_DIV_A 8
`define CDT_DIV_B 32

`endif

/* File: verilog/cdt_pkg.sv */
package cdt_pkg;

    // Operating modes of one timer.
    typedef enum logic [1:0] {
        CDT_M_TIMER   = 2'h0,
        CDT_M_EVENT   = 2'h1,
        CDT_M_ONESHOT = 2'h3,
        CDT_M_RSVD    = 2'h2
    } cdt_mode_t;

    // One-shot sequencer states.
    typedef enum logic {
        CDT_OS_IDLE = 1'b0,
        CDT_OS_RUN  = 1'b1
    } cdt_os_t;

endpackage : cdt_pkg

/* File: verilog/cdt_tick_if.sv */
`timescale 1ns/10ps
// Divided count source enables, one-cycle pulses.
interface cdt_tick_if;
    logic tick_a;
    logic tick_b;
    modport src (output tick_a, output tick_b);
    modport snk (input tick_a, input tick_b);
endinterface : cdt_tick_if

/* File: verilog/cdt_prescale.sv */
`timescale 1ns/10ps
`include "cdt_regs.svh"
module cdt_prescale import cdt_pkg::*; (
    input wire logic clk_i,
    input wire logic rst_i,
    cdt_tick_if.src  tk
);
    localparam int DA = `CDT_DIV_A;
    localparam int DB = `CDT_DIV_B;

    logic [$clog2(DB)-1:0] div_q;

    // Free-running divider shared by both timers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Each enable fires once per full wrap of its low bits.
    assign tk.tick_a = &div_q[$clog2(DA)-1:0];
    assign tk.tick_b = &div_q;
endmodule : cdt_prescale

/* File: verilog/cdt_pin_sync.sv */
`timescale 1ns/10ps
module cdt_pin_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // Two flops; only the second stage is visible outside.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            q_o    <= '0;
        end else begin
            meta_q <= d_i;
            q_o    <= meta_q;
        end
    end
endmodule : cdt_pin_sync

/* File: verilog/cdt_top.sv */
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "cdt_regs.svh"
// Functional notes
// - A timer stays idle until its start flag is one, then counts.
// - Timer mode decrements once per enable of the selected count source.
// - Timer mode underflow reloads, keeps counting and raises the request flag.
// - Event counter can count the neighbour timer's underflows as a cascade.
// - Cascaded counter underflow reloads, keeps counting and raises its flag.
// - One-shot can be triggered by the neighbour timer's underflow.
// - With pulse output on, one-shot drives its pin high when counting starts.
// - One-shot on the tick at count one or zero drives pin low, reloads, stops and raises its flag.
// - External one-shot is armed only with trigger select and start both one.
// - Armed one-shot starts on the trigger pin edge chosen by the edge bit.
// - Pulse output select in timer mode makes the pin a driven timer output.
// - Clearing pulse output select stops pulses and floats the pin.
// - Event mode with reload zero flags every chosen trigger pin edge.
module cdt_top import cdt_pkg::*; #(
    parameter int W = 16
) (
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       wb_cyc_i,
    input  wire logic       wb_stb_i,
    input  wire logic       wb_we_i,
    input  wire logic [7:0] wb_adr_i,
    input  wire logic [3:0] wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic            wb_ack_o,
    output logic            irq_o,
    input  wire logic [1:0] timer_trigger_input_pin_i,
    input  wire logic       first_timer_pulse_output_pin_i,
    output logic            first_timer_pulse_output_pin_o,
    output logic            first_timer_pulse_output_pin_oe_n_o,
    input  wire logic       second_timer_pulse_output_pin_i,
    output logic            second_timer_pulse_output_pin_o,
    output logic            second_timer_pulse_output_pin_oe_n_o
);
    logic [1:0]            start_q;
    logic [1:0]            start_old_q;
    logic [`CDT_CTRL_W-1:0] ctrl_q [2];
    logic [W-1:0]          rld_q [2];
    logic [W-1:0]          cnt_q [2];
    cdt_os_t               os_q [2];
    logic [1:0]            uf_q;
    logic [1:0]            out_q;
    logic [1:0]            oe_n_q;
    logic [1:0]            stat_q;
    logic [1:0]            mask_q;
    logic [1:0]            trig_old_q;
    logic                  ack_q;
    logic [31:0]           rdat_q;
    logic [3:0]            pin_s;
    cdt_mode_t             mode [2];
    logic [1:0]            tick;
    logic [1:0]            pedge;
    logic [1:0]            step;
    logic [1:0]            trig;
    logic [1:0]            ufn;
    logic [1:0]            osgo;
    logic [1:0]            wr_rld;
    logic                  acc;
    logic                  wr;
    logic                  rd_stat;

    cdt_tick_if u_tick ();

    // Divided count sources.
    cdt_prescale u_pre (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tk    (u_tick.src)
    );

    // Pin levels pass two flops before use.
    cdt_pin_sync #(.W(4)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({second_timer_pulse_output_pin_i, first_timer_pulse_output_pin_i,
                 timer_trigger_input_pin_i}),
        .q_o   (pin_s)
    );

    // Merges write data into an old word under the byte enables.
    function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                           input logic [3:0] s);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[8*b +: 8] = d[8*b +: 8];
            end
        end
        return r;
    endfunction : wmerge

    // Picks the count source enable; code 3 selects no source.
    function automatic logic src_tick(input logic [1:0] s, input logic a, input logic b);
        case (s)
            2'h0: return 1'b1;
            2'h1: return a;
            2'h2: return b;
            default: return 1'b0;
        endcase
    endfunction : src_tick

    // Chooses the active edge of a synchronised pin level.
    function automatic logic edge_hit(input logic cur, input logic old, input logic rise);
        return rise ? (cur & ~old) : (~cur & old);
    endfunction : edge_hit

    // Bus request decode; a request is taken once, in the cycle before ack.
    assign acc     = wb_cyc_i & wb_stb_i & ~ack_q;
    assign wr      = acc & wb_we_i;
    assign rd_stat = acc & ~wb_we_i & (wb_adr_i == `CDT_A_STAT);
    assign wr_rld[0] = wr & (wb_adr_i == `CDT_A_RLD0);
    assign wr_rld[1] = wr & (wb_adr_i == `CDT_A_RLD1);

    // Per-timer count step, trigger and underflow decisions.
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            mode[i]  = cdt_mode_t'(ctrl_q[i][`CDT_F_MODE]);
            tick[i]  = src_tick(ctrl_q[i][`CDT_F_SRC], u_tick.tick_a, u_tick.tick_b);
            pedge[i] = edge_hit(pin_s[i], trig_old_q[i], ctrl_q[i][`CDT_F_RISE]);
            // Event source is the neighbour's underflow or the trigger pin.
            step[i]  = ctrl_q[i][`CDT_F_NBR] ? uf_q[1-i] : pedge[i];
            // Hardware trigger needs the select bit; otherwise a start edge fires.
            trig[i]  = ctrl_q[i][`CDT_F_TRIG] ? step[i] : (start_q[i] & ~start_old_q[i]);
            if (mode[i] != CDT_M_EVENT) begin
                step[i] = tick[i];
            end
            osgo[i] = start_q[i] & (mode[i] == CDT_M_ONESHOT) & (os_q[i] == CDT_OS_IDLE) & trig[i];
            if (mode[i] == CDT_M_ONESHOT) begin
                ufn[i] = start_q[i] & (os_q[i] == CDT_OS_RUN) & tick[i] & (cnt_q[i] < W'(2));
            end else begin
                ufn[i] = start_q[i] & step[i] & (cnt_q[i] == '0);
            end
        end
    end

    // Edge history for start flags and trigger pins.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_old_q <= '0;
            trig_old_q  <= '0;
        end else begin
            start_old_q <= start_q;
            trig_old_q  <= pin_s[1:0];
        end
    end

    // Software-written control, reload and mask registers.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_q <= '0;
            ctrl_q  <= '{default: `CDT_RST_CTRL};
            rld_q   <= '{default: `CDT_RST_CNT};
            mask_q  <= '0;
        end else if (wr) begin
            case (wb_adr_i)
                `CDT_A_START: start_q <= 2'(wmerge(32'(start_q), wb_dat_i, wb_sel_i));
                `CDT_A_CTRL0: ctrl_q[0] <= 8'(wmerge(32'(ctrl_q[0]), wb_dat_i, wb_sel_i));
                `CDT_A_CTRL1: ctrl_q[1] <= 8'(wmerge(32'(ctrl_q[1]), wb_dat_i, wb_sel_i));
                `CDT_A_RLD0:  rld_q[0] <= W'(wmerge(32'(rld_q[0]), wb_dat_i, wb_sel_i));
                `CDT_A_RLD1:  rld_q[1] <= W'(wmerge(32'(rld_q[1]), wb_dat_i, wb_sel_i));
                `CDT_A_MASK:  mask_q <= 2'(wmerge(32'(mask_q), wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    // Counters and one-shot sequencers; a stopped timer holds its count unless its reload word is written.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q <= '{default: `CDT_RST_CNT};
            os_q  <= '{default: CDT_OS_IDLE};
            uf_q  <= '0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                uf_q[i] <= ufn[i];
                if (!start_q[i]) begin
                    os_q[i] <= CDT_OS_IDLE;
                    if (wr_rld[i]) begin
                        cnt_q[i] <= W'(wmerge(32'(rld_q[i]), wb_dat_i, wb_sel_i));
                    end
                end else if (mode[i] == CDT_M_ONESHOT) begin
                    case (os_q[i])
                        CDT_OS_IDLE: begin
                            if (osgo[i]) begin
                                os_q[i] <= CDT_OS_RUN;
                            end
                        end
                        CDT_OS_RUN: begin
                            if (ufn[i]) begin
                                cnt_q[i] <= rld_q[i];
                                os_q[i]  <= CDT_OS_IDLE;
                            end else if (tick[i]) begin
                                cnt_q[i] <= cnt_q[i] - 1'b1;
                            end
                        end
                        default: os_q[i] <= CDT_OS_IDLE;
                    endcase
                end else if (ufn[i]) begin
                    cnt_q[i] <= rld_q[i];
                end else if (step[i]) begin
                    cnt_q[i] <= cnt_q[i] - 1'b1;
                end
            end
        end
    end

    // Pulse output levels and pin drive enables.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_q  <= '0;
            oe_n_q <= 2'h3;
        end else begin
            for (int i = 0; i < 2; i++) begin
                // The pin floats unless pulse output is selected in any mode other than event mode.
                oe_n_q[i] <= ~(ctrl_q[i][`CDT_F_PULSE] & (mode[i] != CDT_M_EVENT));
                if (!ctrl_q[i][`CDT_F_PULSE]) begin
                    out_q[i] <= 1'b0;
                end else if (mode[i] == CDT_M_ONESHOT) begin
                    if (osgo[i]) begin
                        out_q[i] <= 1'b1;
                    end else if (ufn[i]) begin
                        out_q[i] <= 1'b0;
                    end
                end else if (mode[i] == CDT_M_TIMER && ufn[i]) begin
                    out_q[i] <= ~out_q[i];
                end
            end
        end
    end

    // Sticky request flags; a new underflow wins over the read clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stat_q <= '0;
        end else begin
            stat_q <= (stat_q & ~{2{rd_stat}}) | uf_q;
        end
    end

    // Bus answer one cycle after the request, with registered read data.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q  <= 1'b0;
            rdat_q <= '0;
        end else begin
            ack_q  <= acc;
            rdat_q <= '0;
            if (acc && !wb_we_i) begin
                case (wb_adr_i)
                    `CDT_A_START: rdat_q <= 32'(start_q);
                    `CDT_A_CTRL0: rdat_q <= 32'(ctrl_q[0]);
                    `CDT_A_CTRL1: rdat_q <= 32'(ctrl_q[1]);
                    `CDT_A_RLD0:  rdat_q <= 32'(rld_q[0]);
                    `CDT_A_RLD1:  rdat_q <= 32'(rld_q[1]);
                    `CDT_A_CNT0:  rdat_q <= 32'(cnt_q[0]);
                    `CDT_A_CNT1:  rdat_q <= 32'(cnt_q[1]);
                    `CDT_A_STAT:  rdat_q <= 32'(stat_q);
                    `CDT_A_MASK:  rdat_q <= 32'(mask_q);
                    `CDT_A_PINS:  rdat_q <= 32'(pin_s);
                    default:      rdat_q <= '0;
                endcase
            end
        end
    end

    // Outputs.
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign irq_o    = |(stat_q & mask_q);
    assign first_timer_pulse_output_pin_o       = out_q[0];
    assign first_timer_pulse_output_pin_oe_n_o  = oe_n_q[0];
    assign second_timer_pulse_output_pin_o      = out_q[1];
    assign second_timer_pulse_output_pin_oe_n_o = oe_n_q[1];

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // A stopped timer without a reload write keeps its count and gives no underflow.
    idle_hold_a: assert property (!start_q[0] && !wr_rld[0] |=> cnt_q[0] == $past(cnt_q[0]) && !uf_q[0])
        else $error("Stopped timer changed its count.");

    // Timer mode steps down by one on a source enable.
    timer_dec_a: assert property (start_q[0] && mode[0] == CDT_M_TIMER && tick[0] && cnt_q[0] != '0
        |=> cnt_q[0] == $past(cnt_q[0]) - 1'b1)
        else $error("Timer mode did not decrement.");

    // Timer underflow reloads and the flag follows one cycle later.
    timer_reload_a: assert property (start_q[0] && mode[0] == CDT_M_TIMER && tick[0] && cnt_q[0] == '0
        |=> cnt_q[0] == $past(rld_q[0]) && uf_q[0] ##1 stat_q[0])
        else $error("Timer underflow did not reload and flag.");

    // The cascaded counter steps on each neighbour underflow.
    cascade_step_a: assert property (start_q[1] && mode[1] == CDT_M_EVENT && ctrl_q[1][`CDT_F_NBR]
        && uf_q[0] && cnt_q[1] != '0 |=> cnt_q[1] == $past(cnt_q[1]) - 1'b1)
        else $error("Cascade did not count a neighbour underflow.");

    // The cascaded counter wraps to its reload value and flags.
    cascade_wrap_a: assert property (start_q[1] && mode[1] == CDT_M_EVENT && ctrl_q[1][`CDT_F_NBR]
        && uf_q[0] && cnt_q[1] == '0 |=> cnt_q[1] == $past(rld_q[1]) ##1 stat_q[1])
        else $error("Cascade underflow did not reload and flag.");

    // A neighbour underflow starts the one-shot and raises its pin.
    os_trigger_a: assert property (start_q[1] && mode[1] == CDT_M_ONESHOT && os_q[1] == CDT_OS_IDLE
        && ctrl_q[1][`CDT_F_TRIG] && ctrl_q[1][`CDT_F_NBR] && uf_q[0] && ctrl_q[1][`CDT_F_PULSE]
        |=> os_q[1] == CDT_OS_RUN && out_q[1])
        else $error("One-shot did not start on neighbour underflow.");

    // The one-shot end lowers the pin, reloads, stops and flags.
    os_end_a: assert property (start_q[1] && mode[1] == CDT_M_ONESHOT && os_q[1] == CDT_OS_RUN
        && tick[1] && cnt_q[1] < W'(2) |=> os_q[1] == CDT_OS_IDLE && !out_q[1]
        && cnt_q[1] == $past(rld_q[1]) ##1 stat_q[1])
        else $error("One-shot end was wrong.");

    // Without the start flag the one-shot never runs.
    os_arm_a: assert property (!start_q[0] |=> os_q[0] == CDT_OS_IDLE)
        else $error("One-shot ran while not armed.");

    // An armed external one-shot starts on the chosen pin edge.
    ext_edge_a: assert property (start_q[0] && mode[0] == CDT_M_ONESHOT && os_q[0] == CDT_OS_IDLE
        && ctrl_q[0][`CDT_F_TRIG] && !ctrl_q[0][`CDT_F_NBR] && pedge[0] |=> os_q[0] == CDT_OS_RUN)
        else $error("One-shot missed the trigger pin edge.");

    // Pulse output select in timer mode drives the pin.
    pin_drive_a: assert property (ctrl_q[0][`CDT_F_PULSE] && mode[0] == CDT_M_TIMER
        |=> !first_timer_pulse_output_pin_oe_n_o)
        else $error("Timer pulse pin not driven.");

    // A cleared select floats the pin and stops toggling.
    pin_float_a: assert property (!ctrl_q[0][`CDT_F_PULSE] |=> first_timer_pulse_output_pin_oe_n_o
        && !first_timer_pulse_output_pin_o)
        else $error("Pin driven with pulse output off.");

    // Reload zero in event mode flags each pin edge two cycles on.
    event_irq_a: assert property (start_q[0] && mode[0] == CDT_M_EVENT && !ctrl_q[0][`CDT_F_NBR]
        && cnt_q[0] == '0 && pedge[0] |-> ##2 stat_q[0])
        else $error("Event edge raised no request.");

    // Timer mode pulse output inverts at every underflow.
    pulse_toggle_a: assert property (mode[0] == CDT_M_TIMER && ctrl_q[0][`CDT_F_PULSE] && ufn[0]
        |=> out_q[0] != $past(out_q[0]))
        else $error("Pulse output did not toggle.");

    // Main scenarios.
    cascade_c: cover property (mode[1] == CDT_M_EVENT && ctrl_q[1][`CDT_F_NBR] && uf_q[1]);
    os_pulse_c: cover property (out_q[1] ##[1:200] !out_q[1] && stat_q[1]);
    event_irq_c: cover property (mode[0] == CDT_M_EVENT && irq_o);
endmodule : cdt_top

/* File: bench/cdt_far_model.sv */
`timescale 1ns/10ps
// Far side: a trigger source on both trigger pins and a pulled-up load on both output pins.
module cdt_far_model (
    input  wire logic       clk_i,
    input  wire logic       pin0_o_i,
    input  wire logic       pin0_oe_n_i,
    input  wire logic       pin1_o_i,
    input  wire logic       pin1_oe_n_i,
    output logic      [1:0] trig_o,
    output logic            pin0_lvl_o,
    output logic            pin1_lvl_o
);
    logic [1:0] trig_q = 2'h0;

    // Trigger levels change only just after a rising edge and then hold.
    assign trig_o = trig_q;

    // A pin that is not driven is pulled high by the load.
    assign pin0_lvl_o = pin0_oe_n_i ? 1'b1 : pin0_o_i;
    assign pin1_lvl_o = pin1_oe_n_i ? 1'b1 : pin1_o_i;

    // Presents one level on one trigger pin.
    task automatic set_trig(input int idx, input logic v);
        @(posedge clk_i);
        trig_q[idx] <= v;
    endtask : set_trig
endmodule : cdt_far_model

/* File: bench/tb.sv */
`timescale 1ns/10ps
`include "cdt_regs.svh"
module tb import cdt_pkg::*;;
    typedef struct {logic [31:0] exp; logic [31:0] msk;} cdt_note_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        irq_o;
    logic [1:0]  trig;
    logic        p0_o, p0_oe_n, p0_lvl, p1_o, p1_oe_n, p1_lvl;
    logic [15:0] lfsr_q = 16'h2073;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc_q = 0;
    int          n, w, r;
    cdt_note_t   exp_q[$];
    cdt_note_t   ent;

    cdt_top cdt_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irq_o(irq_o), .timer_trigger_input_pin_i(trig),
        .first_timer_pulse_output_pin_i(p0_lvl), .first_timer_pulse_output_pin_o(p0_o),
        .first_timer_pulse_output_pin_oe_n_o(p0_oe_n), .second_timer_pulse_output_pin_i(p1_lvl),
        .second_timer_pulse_output_pin_o(p1_o), .second_timer_pulse_output_pin_oe_n_o(p1_oe_n));
    cdt_far_model cdt_far_model_inst (.clk_i(clk_i), .pin0_o_i(p0_o), .pin0_oe_n_i(p0_oe_n),
        .pin1_o_i(p1_o), .pin1_oe_n_i(p1_oe_n), .trig_o(trig), .pin0_lvl_o(p0_lvl), .pin1_lvl_o(p1_lvl));

    // Clock of 25 ns period.
    always #12.5 clk_i = ~clk_i;

    // Cycle count, also the hang limit.
    always @(posedge clk_i) begin
        cyc_q <= cyc_q + 1;
        if (cyc_q == 20000) begin
            bad_count++;
            $display("unexpected at %0t: run hung", $time);
            give_verdict();
        end
    end

    // Takes the oldest note at each read answer and compares it.
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
            if (exp_q.size() == 0) begin
                bad_count++;
                $display("unexpected at %0t: read with no note", $time);
            end else begin
                ent = exp_q.pop_front();
                chk(wb_dat_o & ent.msk, ent.exp, "read data");
            end
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // Next value of the stimulus shift register.
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction : lfsr_next

    // One classic single cycle, held until ack is sampled high.
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_xfer

    task automatic reg_wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_xfer(1'b1, adr, dat);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] adr, input logic [31:0] exp, input logic [31:0] msk);
        exp_q.push_back('{exp, msk});
        wb_xfer(1'b0, adr, 32'h0);
    endtask : reg_rd

    // Counts edges until the chosen pulse pin shows a level.
    task automatic wait_pin(input int idx, input logic lvl, output int cnt);
        cnt = 0;
        while (((idx == 0) ? p0_o : p1_o) !== lvl && cnt < 400) begin
            @(posedge clk_i);
            cnt++;
        end
    endtask : wait_pin

    // Waits for a fresh rise of the interrupt line.
    task automatic wait_irq();
        int k;
        k = 0;
        while (irq_o !== 1'b0 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        while (irq_o !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
    endtask : wait_irq

    // Measures the spacing of request flags, clearing them by reads.
    task automatic irq_gap(input logic [31:0] msk, input int gap);
        int t1;
        reg_rd(`CDT_A_STAT, 32'h0, 32'h0);
        wait_irq();
        t1 = cyc_q;
        reg_rd(`CDT_A_STAT, msk, msk);
        wait_irq();
        chk(cyc_q - t1, gap, "flag spacing");
    endtask : irq_gap

    task automatic give_verdict();
        $display("bad_count %0d tests_run %0d", bad_count, tests_run);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : give_verdict

    // Main sequence.
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        reg_rd(`CDT_A_CTRL0, 32'h0, 32'hFFFFFFFF);
        reg_rd(`CDT_A_RLD1, 32'hFFFF, 32'hFFFFFFFF);
        reg_rd(`CDT_A_CNT0, 32'hFFFF, 32'hFFFFFFFF);
        reg_rd(`CDT_A_STAT, 32'h0, 32'hFFFFFFFF);
        reg_wr(8'h28, 32'hFFFFFFFF);
        reg_rd(8'h28, 32'h0, 32'hFFFFFFFF);
        chk(p0_oe_n, 1'b1, "pin floats after reset");
        reg_wr(`CDT_A_RLD0, 32'h5);
        repeat (6) @(posedge clk_i);
        reg_rd(`CDT_A_CNT0, 32'h5, 32'hFFFF);
        lfsr_q = lfsr_next(lfsr_q);
        r = 32'(lfsr_q[2:0]) + 5;
        reg_wr(`CDT_A_RLD0, 32'(r));
        reg_wr(`CDT_A_MASK, 32'h1);
        reg_wr(`CDT_A_CTRL0, 32'h04);
        reg_wr(`CDT_A_START, 32'h1);
        chk(p0_oe_n, 1'b0, "pin driven");
        wait_pin(0, 1'b1, n);
        wait_pin(0, 1'b0, w);
        chk(w, r + 1, "high time");
        wait_pin(0, 1'b1, w);
        chk(w, r + 1, "low time");
        irq_gap(32'h1, r + 1);
        reg_wr(`CDT_A_CTRL0, 32'h24);
        reg_wr(`CDT_A_RLD0, 32'h1);
        irq_gap(32'h1, 16);
        reg_wr(`CDT_A_CTRL0, 32'h44);
        irq_gap(32'h1, 64);
        reg_wr(`CDT_A_START, 32'h0);
        reg_wr(`CDT_A_CTRL0, 32'h0);
        repeat (4) @(posedge clk_i);
        reg_rd(`CDT_A_STAT, 32'h0, 32'h0);
        reg_rd(`CDT_A_STAT, 32'h0, 32'h3);
        chk({p0_oe_n, p0_o}, 2'h2, "pin released");
        reg_rd(`CDT_A_PINS, 32'hC, 32'hC);
        reg_wr(`CDT_A_RLD0, 32'h3);
        reg_wr(`CDT_A_RLD1, 32'h1);
        reg_wr(`CDT_A_CTRL1, 32'h81);
        reg_wr(`CDT_A_MASK, 32'h2);
        reg_wr(`CDT_A_START, 32'h3);
        irq_gap(32'h2, 8);
        reg_wr(`CDT_A_START, 32'h0);
        reg_wr(`CDT_A_RLD0, 32'h9);
        reg_wr(`CDT_A_RLD1, 32'h4);
        reg_wr(`CDT_A_CTRL1, 32'h8F);
        reg_wr(`CDT_A_START, 32'h3);
        chk(p1_oe_n, 1'b0, "one-shot pin driven");
        wait_pin(1, 1'b1, n);
        wait_pin(1, 1'b0, w);
        chk(w, 4, "one-shot width");
        wait_pin(1, 1'b1, n);
        chk(w + n, 10, "one-shot restart");
        irq_gap(32'h2, 10);
        reg_wr(`CDT_A_START, 32'h0);
        reg_wr(`CDT_A_CTRL1, 32'h07);
        reg_wr(`CDT_A_RLD1, 32'h3);
        reg_wr(`CDT_A_START, 32'h2);
        wait_pin(1, 1'b1, n);
        wait_pin(1, 1'b0, w);
        chk(w, 3, "software start width");
        reg_wr(`CDT_A_START, 32'h0);
        reg_wr(`CDT_A_CTRL1, 32'h0);
        for (int pol = 0; pol < 2; pol++) begin
            reg_wr(`CDT_A_CTRL0, 32'h0F | 32'(pol << 4));
            reg_wr(`CDT_A_RLD0, 32'h6);
            cdt_far_model_inst.set_trig(0, !pol);
            repeat (6) @(posedge clk_i);
            cdt_far_model_inst.set_trig(0, pol[0]);
            repeat (12) @(posedge clk_i);
            chk(p0_o, 1'b0, "fired while not started");
            cdt_far_model_inst.set_trig(0, !pol);
            repeat (6) @(posedge clk_i);
            reg_wr(`CDT_A_START, 32'h1);
            cdt_far_model_inst.set_trig(0, pol[0]);
            wait_pin(0, 1'b1, n);
            wait_pin(0, 1'b0, w);
            chk(w, 6, "triggered width");
            cdt_far_model_inst.set_trig(0, !pol);
            repeat (12) @(posedge clk_i);
            chk(p0_o, 1'b0, "fired on other edge");
            reg_wr(`CDT_A_START, 32'h0);
        end
        reg_wr(`CDT_A_CTRL0, 32'h01);
        reg_wr(`CDT_A_RLD0, 32'h0);
        reg_wr(`CDT_A_MASK, 32'h1);
        reg_wr(`CDT_A_START, 32'h1);
        reg_rd(`CDT_A_STAT, 32'h0, 32'h0);
        cdt_far_model_inst.set_trig(0, 1'b1);
        repeat (8) @(posedge clk_i);
        reg_rd(`CDT_A_STAT, 32'h0, 32'h1);
        cdt_far_model_inst.set_trig(0, 1'b0);
        wait_irq();
        chk(irq_o, 1'b1, "falling edge request");
        reg_wr(`CDT_A_MASK, 32'h0);
        chk(irq_o, 1'b0, "masked request");
        reg_rd(`CDT_A_STAT, 32'h1, 32'h1);
        reg_rd(`CDT_A_STAT, 32'h0, 32'h1);
        repeat (2) @(posedge clk_i);
        give_verdict();
    end
endmodule : tb
